// ===== logic/tone_params.svh
// constants of the tone generator control block
`ifndef TONE_PARAMS_SVH
`define TONE_PARAMS_SVH

// ======================================================================
// register map
`define TONE_ADDR_HIGH_CODE   8'h11
`define TONE_ADDR_LOW_CODE    8'h12
`define TONE_ADDR_CONTROL     8'h13

// ======================================================================
// control fields
`define TONE_BIT_MELODY_EN    0
`define TONE_BIT_DIVIDE_BY_THREE_SELECT_SEL     1
`define TONE_BIT_CLOCK_EN     2
`define TONE_CONTROL_WIDTH    3

// ======================================================================
// reset values
`define TONE_RESET_CODE       8'h00
`define TONE_RESET_CONTROL    3'h0
`define TONE_READ_EMPTY       8'h00

// ======================================================================
// synthesis timing
`define TONE_STEPS_LAST       5'h16
`define TONE_MELODY_HIGH      5'h0c
`define TONE_DIV_LAST         2'h2
`define TONE_SAMPLE_MID       9'h100
`define TONE_SAMPLE_BIAS      10'sh100

`endif

// ===== logic/tone_pkg.sv
// types shared by the tone generator control block
package tone_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  typedef struct packed {
    logic [8:0] prescale;
    logic [4:0] step;
  } synth_t;

  typedef struct packed {
    logic [1:0] count;
    logic       divide_by_three_select_active;
    logic       level;
  } divider_state_t;

  typedef struct packed {
    logic [7:0] high_group_freq_code;
    logic [7:0] low_group_freq_code;
    logic [2:0] clock_melody_control;
    logic [7:0] rdata;
    synth_t     high_synth;
    synth_t     low_synth;
    logic       melody_level;
    logic [8:0] tone_sample;
    logic       tone_oe_n;
    pin_drive_t clock_line;
    pin_drive_t melody_line;
    logic       clock_line_pin;
    logic       clock_line_ff;
    logic       melody_line_pin;
    logic       melody_line_ff;
  } control_state_t;

endpackage

// ===== logic/tone_clock_divider.sv
// generator clock divider: tick strobe and exported clock level
`timescale 1ns/1ns
`default_nettype none
`include "tone_params.svh"

module tone_clock_divider (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // mode
  input  wire logic divide_by_three_select_select,
  // generator timing
  output logic      gen_tick,
  output logic      clock_level
);

  tone_pkg::divider_state_t state;
  tone_pkg::divider_state_t next_state;

  // ======================================================================
  // modulo-3 count, mode taken only at the period boundary
  always_comb begin
    next_state = state;
    if (state.count == `TONE_DIV_LAST || !state.divide_by_three_select_active) begin
      next_state.count = 2'h0;
      next_state.divide_by_three_select_active = divide_by_three_select_select;
    end else begin
      next_state.count = state.count + 2'h1;
    end
    if (next_state.divide_by_three_select_active) begin
      next_state.level = (next_state.count == 2'h0);
    end else begin
      next_state.level = ~state.level;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // one tick per generator clock period
  assign gen_tick = !state.divide_by_three_select_active || state.count == `TONE_DIV_LAST;
  assign clock_level = state.level;

endmodule

`default_nettype wire

// ===== logic/tone_melody_clock_output_control.sv
// frequency codes, clock/melody control and shared pin routing
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "tone_params.svh"

module tone_melody_clock_output_control (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // register port
  input  wire tone_pkg::reg_req_t   reg_req,
  output logic [7:0]                rdata,
  // shared clock port line
  input  wire logic                 clock_line_in,
  input  wire logic                 clock_line_port_ff,
  output tone_pkg::pin_drive_t      clock_line_drive,
  output logic                      clock_line_pin_read,
  output logic                      clock_line_ff_read,
  // shared melody port line
  input  wire logic                 melody_line_in,
  input  wire logic                 melody_line_port_ff,
  output tone_pkg::pin_drive_t      melody_line_drive,
  output logic                      melody_line_pin_read,
  output logic                      melody_line_ff_read,
  // tone pin sample
  output logic [8:0]                tone_sample,
  output logic                      tone_oe_n,
  // generator status
  output logic                      generator_on,
  output logic                      gen_tick
);

  tone_pkg::control_state_t state;
  tone_pkg::control_state_t next_state;

  logic                     clock_level;

  // ======================================================================
  // helpers

  // one period of the sine spans the 23 steps of a synthesizer
  function automatic logic signed [7:0] sine_of(input logic [4:0] step);
    logic signed [7:0] value;
    value = 8'sh00;
    unique case (step)
      5'h00: value = 8'sh00;
      5'h01: value = 8'sh1b;
      5'h02: value = 8'sh34;
      5'h03: value = 8'sh49;
      5'h04: value = 8'sh59;
      5'h05: value = 8'sh62;
      5'h06: value = 8'sh64;
      5'h07: value = 8'sh5e;
      5'h08: value = 8'sh52;
      5'h09: value = 8'sh3f;
      5'h0a: value = 8'sh28;
      5'h0b: value = 8'sh0e;
      5'h0c: value = -8'sh0e;
      5'h0d: value = -8'sh28;
      5'h0e: value = -8'sh3f;
      5'h0f: value = -8'sh52;
      5'h10: value = -8'sh5e;
      5'h11: value = -8'sh64;
      5'h12: value = -8'sh62;
      5'h13: value = -8'sh59;
      5'h14: value = -8'sh49;
      5'h15: value = -8'sh34;
      5'h16: value = -8'sh1b;
      default: value = 8'sh00;
    endcase
    return value;
  endfunction

  // x+2 generator ticks per step, 23 steps per period
  function automatic tone_pkg::synth_t advance(
    input tone_pkg::synth_t s,
    input logic [7:0]       code,
    input logic             tick
  );
    tone_pkg::synth_t r;
    logic [8:0]       last;
    r = s;
    last = {1'b0, code} + 9'h001;
    if (code == `TONE_RESET_CODE) begin
      r = '0;
    end else if (tick) begin
      if (s.prescale >= last) begin
        r.prescale = 9'h000;
        if (s.step >= `TONE_STEPS_LAST) begin
          r.step = 5'h00;
        end else begin
          r.step = s.step + 5'h01;
        end
      end else begin
        r.prescale = s.prescale + 9'h001;
      end
    end
    return r;
  endfunction

  // contribution of one group, silent when its synthesizer is stopped
  function automatic logic signed [9:0] voice(
    input tone_pkg::synth_t s,
    input logic [7:0]       code
  );
    logic signed [9:0] v;
    v = 10'sh000;
    if (code != `TONE_RESET_CODE) begin
      v = 10'(sine_of(s.step));
    end
    return v;
  endfunction

  // ======================================================================
  // generator clock

  tone_clock_divider divider (
    .clock       (clock),
    .rst_n       (rst_n),
    .divide_by_three_select_select (state.clock_melody_control[`TONE_BIT_DIVIDE_BY_THREE_SELECT_SEL]),
    .gen_tick    (gen_tick),
    .clock_level (clock_level)
  );

  // ======================================================================
  // next state

  logic              high_on;
  logic              low_on;
  logic              clock_out_enable;
  logic              divide_by_three_select;
  logic              melody_out_enable;
  logic signed [9:0] high_voice;
  logic signed [9:0] low_voice;
  logic signed [9:0] mix;
  logic [9:0]        biased;
  logic              melody_wave;

  always_comb begin
    next_state = state;

    high_on = state.high_group_freq_code != `TONE_RESET_CODE;
    low_on = state.low_group_freq_code != `TONE_RESET_CODE;
    clock_out_enable = state.clock_melody_control[`TONE_BIT_CLOCK_EN];
    divide_by_three_select =
      state.clock_melody_control[`TONE_BIT_DIVIDE_BY_THREE_SELECT_SEL];
    melody_out_enable = state.clock_melody_control[`TONE_BIT_MELODY_EN];

    // register writes
    if (reg_req.write) begin
      unique case (reg_req.addr)
        `TONE_ADDR_HIGH_CODE: begin
          next_state.high_group_freq_code = reg_req.wdata;
        end
        `TONE_ADDR_LOW_CODE: begin
          next_state.low_group_freq_code = reg_req.wdata;
        end
        `TONE_ADDR_CONTROL: begin
          next_state.clock_melody_control =
            reg_req.wdata[`TONE_CONTROL_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle only
    next_state.rdata = `TONE_READ_EMPTY;
    if (reg_req.read && reg_req.addr == `TONE_ADDR_CONTROL) begin
      next_state.rdata = {5'h00, state.clock_melody_control};
    end

    // synthesizers
    next_state.high_synth =
      advance(state.high_synth, state.high_group_freq_code, gen_tick);
    next_state.low_synth =
      advance(state.low_synth, state.low_group_freq_code, gen_tick);

    // low group about 2 dB below the high group
    high_voice = voice(state.high_synth, state.high_group_freq_code);
    low_voice = voice(state.low_synth, state.low_group_freq_code);
    mix = high_voice + low_voice - (low_voice >>> 3) - (low_voice >>> 4);
    biased = mix + `TONE_SAMPLE_BIAS;

    // tone pin floats once both groups are stopped
    if (high_on || low_on) begin
      next_state.tone_sample = biased[8:0];
      next_state.tone_oe_n = 1'b0;
    end else begin
      next_state.tone_sample = `TONE_SAMPLE_MID;
      next_state.tone_oe_n = 1'b1;
    end

    // melody square wave, 12 of 23 steps high
    melody_wave = state.high_synth.step < `TONE_MELODY_HIGH;
    if (!high_on) begin
      next_state.melody_level = 1'b1;
    end else begin
      next_state.melody_level = melody_wave;
    end

    // clock line: port flip-flop still gates the exported clock
    if (clock_out_enable) begin
      next_state.clock_line.out = clock_level & clock_line_port_ff;
      next_state.clock_line.oe_n = 1'b0;
    end else begin
      next_state.clock_line.out = clock_line_port_ff;
      next_state.clock_line.oe_n = clock_line_port_ff;
    end

    // melody line: same sharing with its port flip-flop
    if (melody_out_enable) begin
      next_state.melody_line.out =
        state.melody_level & melody_line_port_ff;
      next_state.melody_line.oe_n = 1'b0;
    end else begin
      next_state.melody_line.out = melody_line_port_ff;
      next_state.melody_line.oe_n = melody_line_port_ff;
    end

    // port instructions keep reading pin and flip-flop in every mode
    next_state.clock_line_pin = clock_line_in;
    next_state.clock_line_ff = clock_line_port_ff;
    next_state.melody_line_pin = melody_line_in;
    next_state.melody_line_ff = melody_line_port_ff;

    if (divide_by_three_select && !clock_out_enable) begin
      next_state.clock_line_pin = clock_line_in;
    end
  end

  // ======================================================================
  // state register

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.high_group_freq_code <= `TONE_RESET_CODE;
      state.low_group_freq_code <= `TONE_RESET_CODE;
      state.clock_melody_control <= `TONE_RESET_CONTROL;
      state.tone_sample <= `TONE_SAMPLE_MID;
      state.tone_oe_n <= 1'b1;
      state.melody_level <= 1'b1;
      state.clock_line.oe_n <= 1'b1;
      state.melody_line.oe_n <= 1'b1;
      state.clock_line.out <= 1'b1;
      state.melody_line.out <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ======================================================================
  // outputs

  assign rdata = state.rdata;
  assign clock_line_drive = state.clock_line;
  assign melody_line_drive = state.melody_line;
  assign clock_line_pin_read = state.clock_line_pin;
  assign clock_line_ff_read = state.clock_line_ff;
  assign melody_line_pin_read = state.melody_line_pin;
  assign melody_line_ff_read = state.melody_line_ff;
  assign tone_sample = state.tone_sample;
  assign tone_oe_n = state.tone_oe_n;
  assign generator_on = !state.tone_oe_n;

endmodule

`default_nettype wire

// ===== dv/tone_control_properties.sv
// port assertions for the tone control block
`timescale 1ns/1ns
`default_nettype none
module tone_control_properties (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst_n,
  // register port
  input wire tone_pkg::reg_req_t   reg_req,
  input wire logic [7:0]           rdata,
  // shared lines
  input wire logic                 clock_line_in,
  input wire logic                 clock_line_port_ff,
  input wire tone_pkg::pin_drive_t clock_line_drive,
  input wire logic                 clock_line_pin_read,
  input wire logic                 melody_line_port_ff,
  input wire tone_pkg::pin_drive_t melody_line_drive,
  input wire logic                 melody_line_ff_read,
  // generator
  input wire logic                 tone_oe_n,
  input wire logic                 generator_on,
  input wire logic                 gen_tick
);
  // ======================================================================
  // register shadow rebuilt from bus writes
  logic [2:0] ctrl;
  logic [7:0] high;
  logic [7:0] low;
  logic       armed;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 3'h0;
      high <= 8'h00;
      low <= 8'h00;
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
      if (reg_req.write && reg_req.addr == 8'h13) begin
        ctrl <= reg_req.wdata[2:0];
      end
      if (reg_req.write && reg_req.addr == 8'h11) begin
        high <= reg_req.wdata;
      end
      if (reg_req.write && reg_req.addr == 8'h12) begin
        low <= reg_req.wdata;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ======================================================================
  // assertions
  AST_EMPTY_READ: assert property (
    reg_req.read && reg_req.addr != 8'h13 |=> rdata == 8'h00)
    else $error("empty read not zero");
  AST_CTRL_READ: assert property (
    reg_req.read && reg_req.addr == 8'h13 |=> rdata == {5'h00, ctrl})
    else $error("control read wrong");
  AST_TONE_OFF: assert property (
    (high == 8'h00 && low == 8'h00)[*3] |-> tone_oe_n)
    else $error("tone pin driven while off");
  AST_GEN_ON: assert property (
    (high != 8'h00 || low != 8'h00)[*3] |-> generator_on && !tone_oe_n)
    else $error("generator not running");
  AST_CLK_PORT: assert property (
    armed && !ctrl[2] && $stable(ctrl) |-> clock_line_drive ==
    {$past(clock_line_port_ff), $past(clock_line_port_ff)})
    else $error("clock line not in port mode");
  AST_MEL_PORT: assert property (
    armed && !ctrl[0] && $stable(ctrl) |-> melody_line_drive ==
    {$past(melody_line_port_ff), $past(melody_line_port_ff)})
    else $error("melody line not in port mode");
  AST_CLK_DRIVE: assert property (
    (ctrl[2] && clock_line_port_ff)[*2] |-> !clock_line_drive.oe_n)
    else $error("clock line not driven");
  AST_MEL_HIGH: assert property (
    (ctrl[0] && high == 8'h00 && melody_line_port_ff)[*3]
    |-> melody_line_drive.out)
    else $error("melody line not steady high");
  AST_DIV1: assert property (
    (!ctrl[1])[*8] |-> gen_tick)
    else $error("tick missing in full rate");
  AST_DIVIDE_BY_THREE_SELECT: assert property (
    ctrl[1][*8] ##0 gen_tick |=> !gen_tick[*2])
    else $error("tick too close in third rate");
  AST_PIN_READ: assert property (
    armed |-> clock_line_pin_read == $past(clock_line_in))
    else $error("clock line pin read wrong");
  AST_FF_READ: assert property (
    armed |-> melody_line_ff_read == $past(melody_line_port_ff))
    else $error("melody flip-flop read wrong");
endmodule
bind tone_melody_clock_output_control tone_control_properties u_props (
  .clock, .rst_n, .reg_req, .rdata, .clock_line_in, .clock_line_port_ff,
  .clock_line_drive, .clock_line_pin_read, .melody_line_port_ff,
  .melody_line_drive, .melody_line_ff_read, .tone_oe_n, .generator_on,
  .gen_tick
);
`default_nettype wire

// ===== dv/tb_tone_melody_clock_output_control.sv
// self-checking bench for the tone control block
`timescale 1ns/1ns
`default_nettype none
module tb_tone_melody_clock_output_control;
  // ======================================================================
  // signals
  logic                 clock = 1'b0;
  logic                 rst_n = 1'b0;
  tone_pkg::reg_req_t   req = '0;
  logic [7:0]           rdata;
  logic                 cl_in = 1'b1;
  logic                 cl_ff = 1'b1;
  logic                 ml_in = 1'b1;
  logic                 ml_ff = 1'b1;
  tone_pkg::pin_drive_t cl_drv;
  tone_pkg::pin_drive_t ml_drv;
  logic                 gen_on;
  logic                 tone_oe_n;
  logic                 cl_pin_rd;
  logic                 cl_ff_rd;
  logic                 ml_pin_rd;
  logic                 ml_ff_rd;
  logic [8:0]           tone_smp;
  int                   error_cnt = 0;
  int                   comparisons = 0;
  int                   seed = 32'h0da475b5;
  logic [7:0]           d;
  logic [7:0]           rv;
  int                   hi;
  int                   lo;

  always #2 clock = ~clock;

  tone_melody_clock_output_control dut (
    .clock, .rst_n, .reg_req(req), .rdata,
    .clock_line_in(cl_in), .clock_line_port_ff(cl_ff),
    .clock_line_drive(cl_drv), .clock_line_pin_read(cl_pin_rd),
    .clock_line_ff_read(cl_ff_rd), .melody_line_in(ml_in),
    .melody_line_port_ff(ml_ff), .melody_line_drive(ml_drv),
    .melody_line_pin_read(ml_pin_rd), .melody_line_ff_read(ml_ff_rd),
    .tone_sample(tone_smp), .tone_oe_n, .generator_on(gen_on),
    .gen_tick()
  );

  // ======================================================================
  // helpers
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic int span(input int steps, input int x, input logic d3);
    return steps * (x + 2) * (d3 ? 3 : 1);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    req <= '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
    v = rdata;
  endtask
  task automatic idle(input int n);
    @(posedge clock);
    req <= '0;
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    req <= '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  task automatic read_empty();
    logic [7:0] addrs [4];
    addrs = '{8'h11, 8'h12, 8'h13, 8'h20};
    foreach (addrs[i]) begin
      rd(addrs[i], rv);
      check("empty read", rv, 16'h0);
    end
  endtask
  task automatic run_len(input logic v, output int len);
    len = 0;
    while (ml_drv.out === v && len < 3000) begin
      @(negedge clock);
      len++;
    end
    if (len >= 3000) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // ======================================================================
  // scenarios
  initial begin
    do_reset();
    read_empty();
    repeat (24) begin
      d = 8'($random(seed));
      wr(8'h13, d);
      {cl_in, ml_in} <= d[7:6];
      cl_ff <= d[2] | d[5];
      ml_ff <= d[0] | d[4];
      rd(8'h13, rv);
      check("control", rv, {13'h0, d[2:0]});
      check("pin reads", {cl_pin_rd, ml_pin_rd}, {14'h0, d[7:6]});
      check("ff reads", {cl_ff_rd, ml_ff_rd}, {14'h0, cl_ff, ml_ff});
    end
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h5d);
    idle(4);
    check("generator on", gen_on, 16'h1);
    wr(8'h12, 8'h00);
    idle(4);
    check("generator off", {gen_on, tone_oe_n}, 16'h1);
    check("tone mid", tone_smp, 16'h0100);
    // one whole tone period at full rate, high group alone
    wr(8'h13, 8'h00);
    wr(8'h11, 8'h3c);
    idle(4);
    hi = 0;
    lo = 0;
    repeat (span(23, 8'h3c, 1'b0)) begin
      @(negedge clock);
      hi += int'(tone_smp > 9'h100);
      lo += int'(tone_smp < 9'h100);
    end
    check("tone halves", 16'(hi), 16'(lo));
    check("tone above mid", 16'(hi), 16'(span(11, 8'h3c, 1'b0)));
    for (int m = 0; m < 4; m++) begin
      d = m[1] ? 8'h07 : 8'h02;
      wr(8'h13, {5'h00, 1'b1, m[0], 1'b1});
      cl_ff <= 1'b1;
      ml_ff <= 1'b1;
      wr(8'h11, d);
      idle(8);
      hi = 0;
      repeat (12) begin
        @(negedge clock);
        hi += int'(cl_drv.out);
      end
      check("clock highs", 16'(hi), 16'(m[0] ? 4 : 6));
      check("clock driven", cl_drv.oe_n, 16'h0);
      run_len(1'b1, lo);
      run_len(1'b0, lo);
      run_len(1'b1, hi);
      run_len(1'b0, lo);
      check("melody high", 16'(hi), 16'(span(12, d, m[0])));
      check("melody period", 16'(hi + lo), 16'(span(23, d, m[0])));
    end
    wr(8'h11, 8'h00);
    idle(4);
    check("melody steady", ml_drv.out, 16'h1);
    wr(8'h13, 8'h00);
    cl_ff <= 1'b0;
    ml_ff <= 1'b0;
    idle(3);
    check("port drives", {cl_drv, ml_drv}, 16'h0);
    // leave state behind so that the mid-run reset has work to do
    wr(8'h13, 8'h05);
    wr(8'h11, 8'h3c);
    do_reset();
    idle(1);
    check("reset off", {gen_on, tone_oe_n}, 16'h1);
    read_empty();
    print_verdict();
  end
endmodule
`default_nettype wire
